/* sbsr_pkg.sv */
// Package for the SMBus status and data register block
package sbsr_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [1:0] ADDR_STATUS  = 2'h0;
    localparam logic [1:0] ADDR_DATA    = 2'h1;
    localparam logic [1:0] ADDR_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_OWNADR  = 2'h3;

    // ********************************************************
    // Status bit positions
    // ********************************************************
    localparam int BIT_XFER_COMPLETE = 7;
    localparam int BIT_ADDR_SLAVE    = 6;
    localparam int BIT_BUS_BUSY      = 5;
    localparam int BIT_ARB_LOST      = 4;
    localparam int BIT_SLAVE_RW      = 2;
    localparam int BIT_IRQ_PENDING   = 1;
    localparam int BIT_RX_ACK        = 0;

    // ********************************************************
    // Control bit positions
    // ********************************************************
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int BIT_TX_SELECT  = 4;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] RST_CONTROL      = 8'h00;
    localparam logic [6:0] RST_OWNADR       = 7'h00;
    localparam logic [7:0] RST_DATA         = 8'h00;
    localparam logic       RST_XFER_DONE    = 1'b1;
    localparam logic       RST_RX_ACK       = 1'b1;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sbsr_bus_t;

    typedef struct packed {
        logic       byteStart;
        logic       ackRise;
        logic       ackSda;
        logic       addrMatch;
        logic       rwBit;
        logic       startDet;
        logic       stopDet;
        logic       arbLost;
        logic [7:0] rxByte;
    } sbsr_evt_t;

    typedef struct packed {
        logic xferComplete;
        logic addressedAsSlave;
        logic busBusyFlag;
        logic arbLost;
        logic slaveRwDir;
        logic irqPending;
        logic rxAck;
    } sbsr_stat_t;

    typedef struct packed {
        logic       clrArb;
        logic       clrIrq;
    } sbsr_clr_t;

endpackage : sbsr_pkg

/* sbsr_flag.sv */
// Sticky flag: hardware sets, software clears by writing zero
`timescale 1ns/10ps
module sbsr_flag (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Set and clear
    input  wire logic setEvt,
    input  wire logic clrEvt,
    // Flag
    output logic      flag
);

    typedef struct packed {
        logic flag;
    } sbsr_flag_st_t;

    sbsr_flag_st_t st_r;
    sbsr_flag_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Set wins so an event in the clear cycle is kept
        if (setEvt) begin
            st_nxt.flag = 1'b1;
        end else if (clrEvt) begin
            st_nxt.flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag = st_r.flag;

endmodule : sbsr_flag

/* sbsr_regs.sv */
// SMBus status and data registers facing the microcontroller
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
module sbsr_regs (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst,
    // Register port
    input  wire sbsr_pkg::sbsr_bus_t bus,
    output logic [7:0]               rdata,
    // Events from the bus interface logic
    input  wire sbsr_pkg::sbsr_evt_t evt,
    // Settings and data to the bus interface logic
    output logic [7:0]               txByte,
    output logic                     txSelect,
    output logic [6:0]               ownSlaveAddr,
    output logic                     slaveMode,
    // Pins to the processor
    output logic                     xferCompletePin,
    output logic                     irqReq
);

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [7:0]           rdata;
        logic [7:0]           control;
        logic [6:0]           ownAdr;
        logic [7:0]           txData;
        logic [7:0]           rxData;
        logic                 xferComplete;
        logic                 addressedAsSlave;
        logic                 busBusyFlag;
        logic                 slaveRwDir;
        logic                 rxAck;
        logic                 slaveMode;
        logic                 irqReq;
        logic                 pinDone;
    } sbsr_st_t;

    sbsr_st_t           st_r;
    sbsr_st_t           st_nxt;
    sbsr_pkg::sbsr_clr_t clr;
    logic               arbLostFlag;
    logic               irqPendFlag;
    logic [7:0]         statusRd;
    logic               irqSet;

    // ********************************************************
    // Software clearable flags
    // ********************************************************
    // Only a written zero clears; a written one has no effect
    always_comb begin
        clr.clrArb = bus.wr && (bus.addr == sbsr_pkg::ADDR_STATUS)
                     && !bus.wdata[sbsr_pkg::BIT_ARB_LOST];
        clr.clrIrq = bus.wr && (bus.addr == sbsr_pkg::ADDR_STATUS)
                     && !bus.wdata[sbsr_pkg::BIT_IRQ_PENDING];
    end

    // A finished byte or lost arbitration makes an interrupt pending
    assign irqSet = evt.ackRise || evt.arbLost;

    sbsr_flag u_arb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .setEvt  (evt.arbLost),
        .clrEvt  (clr.clrArb),
        .flag    (arbLostFlag)
    );

    sbsr_flag u_irq (
        .sys_clk (sys_clk),
        .rst     (rst),
        .setEvt  (irqSet),
        .clrEvt  (clr.clrIrq),
        .flag    (irqPendFlag)
    );

    // ********************************************************
    // Status read image
    // ********************************************************
    always_comb begin
        statusRd = 8'h00;
        statusRd[sbsr_pkg::BIT_XFER_COMPLETE] = st_r.xferComplete;
        statusRd[sbsr_pkg::BIT_ADDR_SLAVE]    = st_r.addressedAsSlave;
        statusRd[sbsr_pkg::BIT_BUS_BUSY]      = st_r.busBusyFlag;
        statusRd[sbsr_pkg::BIT_ARB_LOST]      = arbLostFlag;
        statusRd[sbsr_pkg::BIT_SLAVE_RW]      = st_r.slaveRwDir;
        statusRd[sbsr_pkg::BIT_IRQ_PENDING]   = irqPendFlag;
        statusRd[sbsr_pkg::BIT_RX_ACK]        = st_r.rxAck;
    end

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;

        // Register writes; status writes touch only the clear logic
        if (bus.wr) begin
            case (bus.addr)
                sbsr_pkg::ADDR_DATA: begin
                    st_nxt.txData = bus.wdata;
                end
                sbsr_pkg::ADDR_CONTROL: begin
                    st_nxt.control = bus.wdata;
                end
                sbsr_pkg::ADDR_OWNADR: begin
                    st_nxt.ownAdr = bus.wdata[7:1];
                end
                default: begin
                    st_nxt.control = st_r.control;
                end
            endcase
        end

        // Register reads: data one cycle later, zero otherwise
        if (bus.rd) begin
            case (bus.addr)
                sbsr_pkg::ADDR_STATUS:  st_nxt.rdata = statusRd;
                sbsr_pkg::ADDR_DATA:    st_nxt.rdata = st_r.rxData;
                sbsr_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.control;
                sbsr_pkg::ADDR_OWNADR:  st_nxt.rdata = {st_r.ownAdr, 1'b0};
                default:                st_nxt.rdata = 8'h00;
            endcase
        end

        // Transfer complete: low while a byte moves, high from the
        // ack rising edge until the next byte starts
        if (evt.ackRise) begin
            st_nxt.xferComplete = 1'b1;
            st_nxt.rxAck = evt.ackSda;
            // Overwritten each byte while receiving; software must keep pace
            if (!st_r.control[sbsr_pkg::BIT_TX_SELECT]) begin
                st_nxt.rxData = evt.rxByte;
            end
        end else if (evt.byteStart) begin
            st_nxt.xferComplete = 1'b0;
        end
        st_nxt.pinDone = st_nxt.xferComplete;

        // Slave addressing
        if (evt.addrMatch) begin
            st_nxt.addressedAsSlave = 1'b1;
            st_nxt.slaveMode = 1'b1;
            st_nxt.slaveRwDir = evt.rwBit;
        end else if (evt.startDet || evt.stopDet) begin
            st_nxt.addressedAsSlave = 1'b0;
        end

        // Bus busy; START wins if both seen together
        if (evt.startDet) begin
            st_nxt.busBusyFlag = 1'b1;
        end else if (evt.stopDet) begin
            st_nxt.busBusyFlag = 1'b0;
        end
        if (evt.stopDet) begin
            st_nxt.slaveMode = 1'b0;
        end

        // Enable masks requests but leaves the pending flag alone
        st_nxt.irqReq = (irqPendFlag || irqSet) &&
                        st_nxt.control[sbsr_pkg::BIT_IRQ_ENABLE];
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.control      <= sbsr_pkg::RST_CONTROL;
            st_r.ownAdr       <= sbsr_pkg::RST_OWNADR;
            st_r.txData       <= sbsr_pkg::RST_DATA;
            st_r.rxData       <= sbsr_pkg::RST_DATA;
            st_r.xferComplete <= sbsr_pkg::RST_XFER_DONE;
            st_r.rxAck        <= sbsr_pkg::RST_RX_ACK;
            st_r.pinDone      <= sbsr_pkg::RST_XFER_DONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************
    // Outputs, all straight from flip-flops
    // ********************************************************
    assign rdata           = st_r.rdata;
    assign txByte          = st_r.txData;
    assign txSelect        = st_r.control[sbsr_pkg::BIT_TX_SELECT];
    assign ownSlaveAddr    = st_r.ownAdr;
    assign slaveMode       = st_r.slaveMode;
    assign xferCompletePin = st_r.pinDone;
    assign irqReq          = st_r.irqReq;

endmodule : sbsr_regs

/* sbsr_regs_asserts.sv */
// Checker for the status and data register block
`timescale 1ns/10ps
module sbsr_regs_asserts (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                rst,
    // Watched ports
    input wire sbsr_pkg::sbsr_bus_t bus,
    input wire logic [7:0]          rdata,
    input wire sbsr_pkg::sbsr_evt_t evt,
    input wire logic [7:0]          txByte,
    input wire logic                txSelect,
    input wire logic [6:0]          ownSlaveAddr,
    input wire logic                slaveMode,
    input wire logic                xferCompletePin,
    input wire logic                irqReq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic wrD;
    logic wrC;
    assign wrD = bus.wr && bus.addr == sbsr_pkg::ADDR_DATA;
    assign wrC = bus.wr && bus.addr == sbsr_pkg::ADDR_CONTROL;
    a_done_clear: assert property (
        evt.byteStart && !evt.ackRise |=> !xferCompletePin)
        else $error("complete pin not cleared");
    a_done_set: assert property (
        evt.ackRise |=> xferCompletePin)
        else $error("complete pin not set");
    a_stat_read: assert property (
        bus.rd && bus.addr == sbsr_pkg::ADDR_STATUS && !evt.byteStart &&
        !evt.ackRise |=> rdata[7] == xferCompletePin && !rdata[3])
        else $error("status read wrong");
    a_irq_cause: assert property (
        $rose(irqReq) |-> $past(evt.ackRise || evt.arbLost || wrC))
        else $error("request without cause");
    a_slave_match: assert property (
        evt.addrMatch && !evt.stopDet |=> slaveMode)
        else $error("slave mode missing");
    a_tx_write: assert property (
        wrD |=> txByte == $past(bus.wdata))
        else $error("transmit byte not loaded");
    a_tx_hold: assert property (
        !wrD |=> $stable(txByte))
        else $error("transmit byte disturbed");
    a_dir_write: assert property (
        wrC |=> txSelect == $past(bus.wdata[sbsr_pkg::BIT_TX_SELECT]))
        else $error("direction not loaded");
    a_own_write: assert property (
        bus.wr && bus.addr == sbsr_pkg::ADDR_OWNADR |=>
        ownSlaveAddr == $past(bus.wdata[7:1]))
        else $error("own address not loaded");
    c_ack: cover property (evt.ackRise ##1 irqReq);
    c_match: cover property (evt.addrMatch ##1 slaveMode);
    c_tx: cover property (wrD ##1 txByte != 8'h00);
endmodule : sbsr_regs_asserts

bind sbsr_regs sbsr_regs_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
    .bus(bus), .rdata(rdata), .evt(evt), .txByte(txByte),
    .txSelect(txSelect), .ownSlaveAddr(ownSlaveAddr),
    .slaveMode(slaveMode), .xferCompletePin(xferCompletePin),
    .irqReq(irqReq));

/* sbsr_link_model.sv */
// Model of the bus interface logic driving the event port
`timescale 1ns/10ps
module sbsr_link_model (
    // Clock
    input wire logic            sys_clk,
    // Events to the registers
    output sbsr_pkg::sbsr_evt_t evt
);
    initial evt = '0;
    // One pulse; qualifiers and data byte then go inverted, not cleared
    task automatic send(input sbsr_pkg::sbsr_evt_t e);
        @(posedge sys_clk);
        evt <= e;
        @(posedge sys_clk);
        evt <= sbsr_pkg::sbsr_evt_t'(~e & 16'h28FF);
    endtask : send
endmodule : sbsr_link_model

/* sbsr_regs_tb.sv */
// Self-checking testbench for the status and data registers
`timescale 1ns/10ps
module sbsr_regs_tb;
    // ****
    // Signals and instances
    // ****
    logic                sys_clk;
    logic                rst;
    sbsr_pkg::sbsr_bus_t bus;
    logic [7:0]          rdata;
    sbsr_pkg::sbsr_evt_t evt;
    logic [7:0]          txByte;
    logic                txSelect;
    logic [6:0]          ownSlaveAddr;
    logic                slaveMode;
    logic                xferCompletePin;
    logic                irqReq;
    int                  err_total = 0;
    int                  checks_done = 0;
    int                  cycles = 0;
    sbsr_regs dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .evt(evt), .txByte(txByte), .txSelect(txSelect),
        .ownSlaveAddr(ownSlaveAddr), .slaveMode(slaveMode),
        .xferCompletePin(xferCompletePin), .irqReq(irqReq));
    sbsr_link_model u_link (.sys_clk(sys_clk), .evt(evt));
    // ****
    // Helpers
    // ****
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk8
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp,
                      input logic [7:0] m = 8'hFF);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 chk8(rdata & m, exp & m);
    endtask : rd
    // Event word: pulses in 15:8 with ackSda at 13, rwBit at 11
    task automatic ev(input logic [15:0] v);
        u_link.send(sbsr_pkg::sbsr_evt_t'(v));
        #1;
    endtask : ev
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd(sbsr_pkg::ADDR_STATUS, 8'h81);
        chk8({7'h00, xferCompletePin}, 8'h01);
    endtask : t_reset
    task automatic t_rx();
        ev(16'h0400);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA1);
        ev(16'h8000);
        chk8({7'h00, xferCompletePin}, 8'h00);
        rd(sbsr_pkg::ADDR_STATUS, 8'h21);
        ev(16'h60A5);
        chk8({7'h00, xferCompletePin}, 8'h01);
        chk8({7'h00, irqReq}, 8'h00);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA3);
        rd(sbsr_pkg::ADDR_DATA, 8'hA5);
        wr(sbsr_pkg::ADDR_CONTROL, 8'h40);
        settle();
        chk8({7'h00, irqReq}, 8'h01);
        wr(sbsr_pkg::ADDR_STATUS, 8'hFF);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA3);
        wr(sbsr_pkg::ADDR_CONTROL, 8'h00);
        settle();
        chk8({7'h00, irqReq}, 8'h00);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA3);
        wr(sbsr_pkg::ADDR_STATUS, 8'h00);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA1);
    endtask : t_rx
    task automatic t_arb();
        ev(16'h0100);
        rd(sbsr_pkg::ADDR_STATUS, 8'hB3);
        wr(sbsr_pkg::ADDR_STATUS, 8'hEF);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA3);
        wr(sbsr_pkg::ADDR_STATUS, 8'h00);
        rd(sbsr_pkg::ADDR_STATUS, 8'hA1);
    endtask : t_arb
    task automatic t_slave();
        wr(sbsr_pkg::ADDR_OWNADR, 8'h55);
        rd(sbsr_pkg::ADDR_OWNADR, 8'h54);
        chk8({1'b0, ownSlaveAddr}, 8'h2A);
        ev(16'h1800);
        chk8({7'h00, slaveMode}, 8'h01);
        rd(sbsr_pkg::ADDR_STATUS, 8'hE5);
        ev(16'h0200);
        chk8({7'h00, slaveMode}, 8'h00);
        rd(sbsr_pkg::ADDR_STATUS, 8'h81, 8'hFB);
    endtask : t_slave
    task automatic t_tx();
        wr(sbsr_pkg::ADDR_CONTROL, 8'h50);
        wr(sbsr_pkg::ADDR_DATA, 8'h3C);
        #1 chk8({7'h00, txSelect}, 8'h01);
        chk8(txByte, 8'h3C);
        ev(16'h8000);
        ev(16'h40C3);
        chk8({7'h00, irqReq}, 8'h01);
        chk8(txByte, 8'h3C);
        rd(sbsr_pkg::ADDR_STATUS, 8'h82, 8'hFB);
        rd(sbsr_pkg::ADDR_DATA, 8'hA5);
    endtask : t_tx
    // ****
    // Clock, reset and run
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        bus = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_rx();
        t_arb();
        t_slave();
        t_tx();
        test_done();
    end
    // Whole run needs under a hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            test_done();
        end
    end
endmodule : sbsr_regs_tb
